// ===== src/tcm_map.svh
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH
// register indices on the plain port
`define TCM_CTRL0_IDX 4'h0
`define TCM_MODE0_IDX 4'h5
`define TCM_START_IDX 4'ha
// mode register layout
`define TCM_MODE_RSVD_MASK 8'hc0
`define TCM_BUF_BD_BIT 5
`define TCM_BUF_AC_BIT 4
// control register: bits 2..0 prescaler
`define TCM_CTRL_MASK 8'h07
// prescaler division counts
`define TCM_DIV4 16'h0003
`define TCM_DIV16 16'h000f
`define TCM_DIV64 16'h003f
`define TCM_DIV256 16'h00ff
`define TCM_DIV1024 16'h03ff
`endif

// ===== src/tcm_pkg.sv
package tcm_pkg;
	// counter clock source choice
	typedef enum logic [3:0] {
		TCM_SRC_D1 = 4'b0000,
		TCM_SRC_D4 = 4'b0001,
		TCM_SRC_D16 = 4'b0010,
		TCM_SRC_D64 = 4'b0011,
		TCM_SRC_D256 = 4'b0100,
		TCM_SRC_D1024 = 4'b0101,
		TCM_SRC_EXTA = 4'b0110,
		TCM_SRC_EXTB = 4'b0111,
		TCM_SRC_EXTC = 4'b1000,
		TCM_SRC_EXTD = 4'b1001,
		TCM_SRC_CASC = 4'b1010,
		TCM_SRC_NONE = 4'b1011
	} tcm_src_t;
	// operating modes
	typedef enum logic [3:0] {
		TCM_MD_NORMAL = 4'b0000,
		TCM_MD_PWM1 = 4'b0010,
		TCM_MD_PWM2 = 4'b0011,
		TCM_MD_PHASE1 = 4'b0100,
		TCM_MD_PHASE2 = 4'b0101,
		TCM_MD_PHASE3 = 4'b0110,
		TCM_MD_PHASE4 = 4'b0111,
		TCM_MD_RSPWM = 4'b1000,
		TCM_MD_CPWM1 = 4'b1101,
		TCM_MD_CPWM2 = 4'b1110,
		TCM_MD_CPWM3 = 4'b1111
	} tcm_mode_t;
	// bus answer
	typedef struct packed {
		logic [7:0] rdata;
	} tcm_rd_t;
	// all state of the block
	typedef struct packed {
		logic [4:0][2:0] clk_sel;
		logic [4:0][1:0] buf_pair;
		logic [4:0][3:0] op_mode;
		logic [4:0] run;
		logic [15:0] pre_cnt;
		logic [3:0] ext_meta;
		logic [3:0] ext_sync;
		logic [3:0] ext_prev;
		logic [4:0][15:0] counter;
		logic [4:0] cnt_en;
		logic ch2_wrap;
		tcm_rd_t rd;
	} tcm_state_t;
endpackage : tcm_pkg

// ===== src/tcm_timer.sv
`timescale 1ns/10ps
module tcm_timer
	import tcm_pkg::*;
#(
	parameter int CNT_W = 16
)(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic ext_clk_pin_a_i,
	input wire logic ext_clk_pin_b_i,
	input wire logic ext_clk_pin_c_i,
	input wire logic ext_clk_pin_d_i,
	input wire logic [4:0] phase_dir_up_i,
	input wire logic [4:0] cap_cmp_c_i,
	input wire logic [4:0] cap_cmp_d_i,
	output logic [4:0] cnt_en_o,
	output logic [4:0][15:0] channel_counter_o,
	output logic [4:0] buffer_pair_a_c_o,
	output logic [4:0] buffer_pair_b_d_o,
	output logic [4:0][3:0] op_mode_o,
	output logic [4:0] cap_cmp_c_o,
	output logic [4:0] cap_cmp_d_o
);
`include "tcm_map.svh"

	tcm_state_t cur_ff;
	tcm_state_t nxt_st;
	logic [4:0] tick;
	logic [3:0] ext_edge;
	logic [15:0] pre_all;
	logic [3:0] idx;

	// prescaler taps, one-cycle enables off the free running count
	function automatic logic div_tick(input logic [15:0] cnt, input logic [15:0] msk);
		div_tick = ((cnt & msk) == msk);
	endfunction : div_tick

	// phase counting modes 4'b01xx
	function automatic logic is_phase(input logic [3:0] md);
		is_phase = (md[3:2] == 2'b01);
	endfunction : is_phase

	// source decode per channel
	function automatic tcm_src_t src_of(input int ch, input logic [2:0] sel);
		tcm_src_t s;
		s = TCM_SRC_NONE;
		case (ch)
			0:
			begin
				case (sel)
					3'b000: s = TCM_SRC_D1;
					3'b001: s = TCM_SRC_D4;
					3'b010: s = TCM_SRC_D16;
					3'b100: s = TCM_SRC_EXTA;
					3'b101: s = TCM_SRC_EXTB;
					3'b110: s = TCM_SRC_EXTC;
					3'b111: s = TCM_SRC_EXTD;
					default: s = TCM_SRC_NONE;
				endcase
			end
			1:
			begin
				case (sel)
					3'b000: s = TCM_SRC_D1;
					3'b001: s = TCM_SRC_D4;
					3'b011: s = TCM_SRC_D64;
					3'b100: s = TCM_SRC_EXTA;
					3'b101: s = TCM_SRC_EXTB;
					3'b111: s = TCM_SRC_CASC;
					default: s = TCM_SRC_NONE;
				endcase
			end
			2:
			begin
				case (sel)
					3'b000: s = TCM_SRC_D1;
					3'b001: s = TCM_SRC_D4;
					3'b010: s = TCM_SRC_D16;
					3'b011: s = TCM_SRC_D64;
					3'b100: s = TCM_SRC_EXTA;
					3'b101: s = TCM_SRC_EXTB;
					3'b110: s = TCM_SRC_EXTC;
					default: s = TCM_SRC_D1024;
				endcase
			end
			default:
			begin
				case (sel)
					3'b000: s = TCM_SRC_D1;
					3'b001: s = TCM_SRC_D4;
					3'b010: s = TCM_SRC_D16;
					3'b011: s = TCM_SRC_D64;
					3'b100: s = TCM_SRC_D256;
					3'b101: s = TCM_SRC_D1024;
					3'b110: s = TCM_SRC_EXTA;
					default: s = TCM_SRC_EXTB;
				endcase
			end
		endcase
		return s;
	endfunction : src_of

	// rising edges of the synchronised pins
	assign ext_edge = cur_ff.ext_sync & ~cur_ff.ext_prev;
	assign pre_all = cur_ff.pre_cnt;
	assign idx = reg_addr_i;

	// clock source to per-channel tick
	always_comb
	begin
		tick = '0;
		for (int c = 0; c < 5; c++)
		begin
			case (src_of(c, cur_ff.clk_sel[c]))
				TCM_SRC_D1: tick[c] = 1'b1;
				TCM_SRC_D4: tick[c] = div_tick(pre_all, `TCM_DIV4);
				TCM_SRC_D16: tick[c] = div_tick(pre_all, `TCM_DIV16);
				TCM_SRC_D64: tick[c] = div_tick(pre_all, `TCM_DIV64);
				TCM_SRC_D256: tick[c] = div_tick(pre_all, `TCM_DIV256);
				TCM_SRC_D1024: tick[c] = div_tick(pre_all, `TCM_DIV1024);
				TCM_SRC_EXTA: tick[c] = ext_edge[0];
				TCM_SRC_EXTB: tick[c] = ext_edge[1];
				TCM_SRC_EXTC: tick[c] = ext_edge[2];
				TCM_SRC_EXTD: tick[c] = ext_edge[3];
				TCM_SRC_CASC: tick[c] = cur_ff.ch2_wrap;
				default: tick[c] = 1'b0;
			endcase
		end
		// phase counting: pins a/b drive ch1, c/d drive ch2, not the prescaler
		if (is_phase(cur_ff.op_mode[1]))
			tick[1] = ext_edge[0] | ext_edge[1];
		if (is_phase(cur_ff.op_mode[2]))
			tick[2] = ext_edge[2] | ext_edge[3];
	end

	// next state
	always_comb
	begin
		nxt_st = cur_ff;
		nxt_st.pre_cnt = cur_ff.pre_cnt + 16'h0001;
		nxt_st.ext_meta = {ext_clk_pin_d_i, ext_clk_pin_c_i, ext_clk_pin_b_i, ext_clk_pin_a_i};
		nxt_st.ext_sync = cur_ff.ext_meta;
		nxt_st.ext_prev = cur_ff.ext_sync;
		nxt_st.cnt_en = tick & cur_ff.run;
		nxt_st.ch2_wrap = 1'b0;
		// counters advance, phase mode may count down
		for (int c = 0; c < 5; c++)
		begin
			if (tick[c] && cur_ff.run[c])
			begin
				if (is_phase(cur_ff.op_mode[c]) && !phase_dir_up_i[c])
					nxt_st.counter[c] = cur_ff.counter[c] - 16'h0001;
				else
					nxt_st.counter[c] = cur_ff.counter[c] + 16'h0001;
			end
		end
		// ch2 overflow or underflow, one-cycle strobe
		if (tick[2] && cur_ff.run[2])
		begin
			if (is_phase(cur_ff.op_mode[2]) && !phase_dir_up_i[2])
				nxt_st.ch2_wrap = (cur_ff.counter[2] == 16'h0000);
			else
				nxt_st.ch2_wrap = (cur_ff.counter[2] == 16'hffff);
		end
		// register writes
		if (reg_wr_i)
		begin
			if (idx < `TCM_MODE0_IDX)
				nxt_st.clk_sel[idx] = reg_wdata_i[2:0];
			else if (idx < `TCM_START_IDX)
			begin
				nxt_st.op_mode[idx - `TCM_MODE0_IDX] = reg_wdata_i[3:0];
				// bits 5..4 exist only on ch0, ch3, ch4
				if (idx != 4'h6 && idx != 4'h7)
					nxt_st.buf_pair[idx - `TCM_MODE0_IDX] =
						reg_wdata_i[`TCM_BUF_BD_BIT:`TCM_BUF_AC_BIT];
			end
			else if (idx == `TCM_START_IDX)
				nxt_st.run = reg_wdata_i[4:0];
		end
		// read answer, one cycle later
		nxt_st.rd.rdata = 8'h00;
		if (reg_rd_i)
		begin
			if (idx < `TCM_MODE0_IDX)
				nxt_st.rd.rdata = {5'h00, cur_ff.clk_sel[idx]};
			else if (idx < `TCM_START_IDX)
				nxt_st.rd.rdata = `TCM_MODE_RSVD_MASK
					| {2'b00, cur_ff.buf_pair[idx - `TCM_MODE0_IDX],
					cur_ff.op_mode[idx - `TCM_MODE0_IDX]};
			else if (idx == `TCM_START_IDX)
				nxt_st.rd.rdata = {3'b000, cur_ff.run};
		end
		if (!rst_n_i)
			nxt_st = '0;
	end

	// state register
	always_ff @(posedge clk_sys_i)
	begin
		cur_ff <= nxt_st;
	end

	// outputs
	assign reg_rdata_o = cur_ff.rd.rdata;
	assign cnt_en_o = cur_ff.cnt_en;
	assign channel_counter_o = cur_ff.counter;
	assign op_mode_o = cur_ff.op_mode;
	always_comb
	begin
		for (int c = 0; c < 5; c++)
		begin
			buffer_pair_b_d_o[c] = cur_ff.buf_pair[c][1];
			buffer_pair_a_c_o[c] = cur_ff.buf_pair[c][0];
			cap_cmp_d_o[c] = cap_cmp_d_i[c] & ~cur_ff.buf_pair[c][1];
			cap_cmp_c_o[c] = cap_cmp_c_i[c] & ~cur_ff.buf_pair[c][0];
		end
	end
endmodule : tcm_timer

// ===== tb/tcm_timer_assertions.sv
`timescale 1ns/10ps
module tcm_chk
	import tcm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [4:0] cnt_en_o,
	input wire logic [4:0][15:0] channel_counter_o,
	input wire logic [4:0] buffer_pair_a_c_o,
	input wire logic [4:0] buffer_pair_b_d_o,
	input wire logic [4:0][3:0] op_mode_o,
	input wire logic [4:0] cap_cmp_c_i,
	input wire logic [4:0] cap_cmp_d_i,
	input wire logic [4:0] cap_cmp_c_o,
	input wire logic [4:0] cap_cmp_d_o
);
	// one clock domain, checks idle in reset
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	chk_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data out of slot");
	chk_rsvd_ones: assert property (reg_rd_i && reg_addr_i inside {[4'h5:4'h9]}
		|=> reg_rdata_o[7:6] == 2'b11) else $error("reserved bits not one");
	chk_no_pair12: assert property ({buffer_pair_a_c_o[2:1], buffer_pair_b_d_o[2:1]} == 4'h0)
		else $error("pairing on channel 1 or 2");
	chk_c_mask: assert property (cap_cmp_c_o == (cap_cmp_c_i & ~buffer_pair_a_c_o))
		else $error("c event mask");
	chk_d_mask: assert property (cap_cmp_d_o == (cap_cmp_d_i & ~buffer_pair_b_d_o))
		else $error("d event mask");
	chk_mode_wr: assert property (reg_wr_i && reg_addr_i == 4'h5
		|=> {4'h0, op_mode_o[0]} == ($past(reg_wdata_i) & 8'h0f)) else $error("mode field");
	chk_pair_wr: assert property (reg_wr_i && reg_addr_i == 4'h8
		|=> {2'h0, buffer_pair_b_d_o[3], buffer_pair_a_c_o[3], 4'h0} == ($past(reg_wdata_i) & 8'h30))
		else $error("pair bits");
	chk_cnt_step: assert property (cnt_en_o[0]
		|-> channel_counter_o[0] == $past(channel_counter_o[0]) + 16'h0001) else $error("count step");
endmodule : tcm_chk
bind tcm_timer tcm_chk u_chk (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .cnt_en_o, .channel_counter_o, .buffer_pair_a_c_o,
	.buffer_pair_b_d_o, .op_mode_o, .cap_cmp_c_i, .cap_cmp_d_i, .cap_cmp_c_o, .cap_cmp_d_o);

// ===== tb/test_tcm_timer.sv
`timescale 1ns/10ps
module test_tcm_timer import tcm_pkg::*;;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
	logic [3:0] adr = 4'h0, ext = 4'h0;
	logic [7:0] wd = 8'h00, rdata, v;
	logic [4:0] cci = 5'h00, cdi = 5'h00, en;
	int num_errors = 0, checked = 0, cnt [5];
	logic [7:0] exp_q [$];
	logic [7:0] ml [11] = '{8'h80, 8'h82, 8'h88, 8'h8d, 8'h8e, 8'h8f, 8'h63, 8'h64, 8'h65,
		8'h66, 8'h67};
	int dv [4][8] = '{'{1, 4, 16, 0, 0, 0, 0, 0}, '{1, 4, 0, 64, 0, 0, 0, 0},
		'{1, 4, 16, 64, 0, 0, 0, 1024}, '{1, 4, 16, 64, 256, 1024, 0, 0}};
	// block under test
	tcm_timer dut (.clk_sys_i, .rst_n_i, .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .ext_clk_pin_a_i(ext[0]), .ext_clk_pin_b_i(ext[1]),
		.ext_clk_pin_c_i(ext[2]), .ext_clk_pin_d_i(ext[3]), .phase_dir_up_i(5'h00),
		.cap_cmp_c_i(cci), .cap_cmp_d_i(cdi), .cnt_en_o(en), .channel_counter_o(),
		.buffer_pair_a_c_o(), .buffer_pair_b_d_o(), .op_mode_o(), .cap_cmp_c_o(), .cap_cmp_d_o());
	// 100 mhz clock
	initial forever #5 clk_sys_i = ~clk_sys_i;
	task close_out;
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : cyc
	task wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		adr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys_i);
		rd <= 1'b0;
	endtask : rreg
	// three pin pulses must give three counts
	task ext_run(input int c, input int k, input int p);
		wreg(4'(c), 8'(k));
		wreg(4'ha, 8'(1 << c));
		cnt[c] = 0;
		repeat (3)
		begin
			ext[p] <= 1'b1;
			cyc(4);
			ext[p] <= 1'b0;
			cyc(4);
		end
		cyc(6);
		chk(16'(cnt[c]), 16'h0003);
		wreg(4'ha, 8'h00);
	endtask : ext_run
	// random event inputs, read slot tracking
	always @(posedge clk_sys_i)
	begin
		rd_seen <= rd;
		cci <= 5'($urandom);
		cdi <= 5'($urandom);
	end
	// compare read answers, count advances
	always @(negedge clk_sys_i)
	begin
		if (rd_seen)
			chk(16'(rdata), 16'(exp_q.pop_front()));
		for (int i = 0; i < 5; i++)
			cnt[i] += 32'(en[i]);
	end
	initial
	begin
		void'($urandom(32'h4158));
		cyc(20);
		rst_n_i <= 1'b1;
		// reset values, unmapped places read zero
		for (int a = 0; a < 16; a++)
			rreg(4'(a), (a > 4 && a < 10) ? 8'hc0 : 8'h00);
		// channel 2 down-count wrap feeds channel 1
		wreg(4'h6, 8'hc2);
		wreg(4'h7, 8'hc4);
		wreg(4'h1, 8'h07);
		wreg(4'ha, 8'h06);
		cnt = '{default: 0};
		ext[2] <= 1'b1;
		cyc(8);
		ext[2] <= 1'b0;
		cyc(6);
		chk(16'(cnt[1]), 16'h0001);
		chk(16'(cnt[2]), 16'h0001);
		// phase mode on channel 1 with a /1 code, counters stopped first
		wreg(4'ha, 8'h00);
		wreg(4'h6, 8'hc4);
		wreg(4'h1, 8'h00);
		wreg(4'ha, 8'h02);
		cnt[1] = 0;
		cyc(64);
		chk(16'(cnt[1]), 16'h0000);
		wreg(4'ha, 8'h00);
		// every permitted mode code reads back, only where the channel allows it
		foreach (ml[i])
		begin
			wreg(ml[i][7:4], {4'hc, ml[i][3:0]});
			rreg(ml[i][7:4], {4'hc, ml[i][3:0]});
		end
		// random pairing bits, forced off on channels 1 and 2
		for (int c = 0; c < 5; c++)
		begin
			v = {2'b11, (c == 1 || c == 2) ? 2'b00 : 2'($urandom), 4'h2};
			wreg(4'(c + 5), v);
			rreg(4'(c + 5), v);
		end
		// every prescaler code over a 1024-cycle window
		for (int c = 0; c < 5; c++)
			for (int k = 0; k < 8; k++)
			begin
				wreg(4'(c), 8'(k));
				wreg(4'ha, 8'(1 << c));
				cyc(2);
				cnt[c] = 0;
				cyc(1024);
				v = 8'(c > 3 ? 3 : c);
				chk(16'(cnt[c]), 16'(dv[v][k] ? 1024 / dv[v][k] : 0));
				wreg(4'ha, 8'h00);
			end
		// external pin sources
		for (int p = 0; p < 4; p++)
			ext_run(0, p + 4, p);
		ext_run(2, 6, 2);
		ext_run(3, 6, 0);
		ext_run(4, 7, 1);
		close_out();
	end
	// hang guard
	initial
	begin
		#1_000_000;
		num_errors++;
		close_out();
	end
endmodule : test_tcm_timer
